// *** hw/pfpp_port.sv ***
// parallel flash programming port: handshake, command decode, page buffer, flash model
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - selector picks command, address halves or data
// - command select stores whole 16-bit word
// - decode read, write, write-and-lock commands
// - decode erase-write variants and chip erase
// - decode general bit set and clear
// - decode general query, secure set, secure query
// - transfer ends with strobe and ready high
// - capture selector and word, drop ready
// - write executes, waits strobe high, raises ready
// - read drives word, pulls present low
// - enable high releases bus, present high; ready after strobe high
// - new command commits pending page first
// - chained reads advance address, pair reloadable
// - page buffer commits on page change, increments
// - lock variants lock, erase variants erase first
// - chip erase aborts if any region locked
// - lock set/clear mask, chip erase clears
// - lock query returns per-region lock mask
// - ready means idle, present shows bus direction
module pfpp_port #(
    parameter int PAGE_AW   = 7,
    parameter int PAGES_AW  = 9,
    parameter int REGION_AW = 5,
    parameter int GP_BITS   = 3
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  field_select_bus,
    input  wire logic [15:0] word_bus_in,
    output logic      [15:0] word_bus_out,
    output logic             word_bus_oe,
    input  wire logic        command_strobe_n,
    input  wire logic        read_drive_enable_n,
    output logic             port_ready_out,
    output logic             read_word_present_n,
    output logic             secure_active
);
    localparam int ADDR_W    = PAGE_AW + PAGES_AW;
    localparam int LOCK_BITS = 1 << (PAGES_AW - REGION_AW);
    localparam int PAGE_W    = 1 << PAGE_AW;

    if (ADDR_W > 32 || REGION_AW > PAGES_AW || LOCK_BITS > 16 || GP_BITS < 1
        || GP_BITS > 16 || PAGE_AW < 1) begin : gen_bad_params
        $error("pfpp_port: parameters out of range");
    end

    function automatic logic is_write_cmd(input logic [15:0] c);
        is_write_cmd = (c == pfpp_pkg::CMD_PAGE_WRITE) || (c == pfpp_pkg::CMD_PAGE_WRITE_LOCK)
                    || (c == pfpp_pkg::CMD_ERASE_THEN_WRITE)
                    || (c == pfpp_pkg::CMD_ERASE_WRITE_LOCK);
    endfunction : is_write_cmd

    function automatic logic has_erase(input logic [15:0] c);
        has_erase = (c == pfpp_pkg::CMD_ERASE_THEN_WRITE)
                 || (c == pfpp_pkg::CMD_ERASE_WRITE_LOCK);
    endfunction : has_erase

    function automatic logic has_lock(input logic [15:0] c);
        has_lock = (c == pfpp_pkg::CMD_PAGE_WRITE_LOCK)
                || (c == pfpp_pkg::CMD_ERASE_WRITE_LOCK);
    endfunction : has_lock

    function automatic logic is_fetch_cmd(input logic [15:0] c);
        is_fetch_cmd = (c == pfpp_pkg::CMD_FLASH_READ) || (c == pfpp_pkg::CMD_LOCK_QUERY)
                    || (c == pfpp_pkg::CMD_GP_BIT_QUERY)
                    || (c == pfpp_pkg::CMD_SECURE_BIT_QUERY);
    endfunction : is_fetch_cmd

    // pin synchronisers; the bus is only read after the strobe has settled
    logic [3:0]                 selMeta;
    logic [3:0]                 selSync;
    logic [15:0]                wordMeta;
    logic [15:0]                wordSync;
    logic                       strobeMeta;
    logic                       strobeN;
    logic                       oeMeta;
    logic                       oeN;

    pfpp_pkg::pfpp_state_type   state;
    logic [3:0]                 capSel;
    logic [15:0]                capWord;
    logic [15:0]                cmd;
    logic [15:0]                addrLow;
    logic [15:0]                addrHigh;
    logic [PAGES_AW-1:0]        bufPage;
    logic [PAGE_W-1:0]          loaded;
    logic                       dirty;
    logic [PAGE_AW-1:0]         commitIdx;
    logic [ADDR_W-1:0]          eraseIdx;
    logic [LOCK_BITS-1:0]       lockBits;
    logic [GP_BITS-1:0]         gpBits;
    logic                       secureBit;

    wire  [31:0]                addrFull  = {addrHigh, addrLow};
    wire  [31:0]                addrNext  = addrFull + 32'h1;
    wire  [ADDR_W-1:0]          wordAddr  = addrFull[ADDR_W-1:0];
    wire  [PAGES_AW-1:0]        curPage   = wordAddr[ADDR_W-1:PAGE_AW];
    wire  [PAGE_AW-1:0]         curIdx    = wordAddr[PAGE_AW-1:0];
    wire  [PAGES_AW-REGION_AW-1:0] bufRegion = bufPage[PAGES_AW-1:REGION_AW];
    wire                        pageLocked = lockBits[bufRegion];
    wire                        lastIdx   = (commitIdx == PAGE_AW'(PAGE_W - 1));
    wire                        lastErase = (eraseIdx == {ADDR_W{1'b1}});

    // selector decode; anything else selects no register
    wire selCmd  = (capSel == pfpp_pkg::MODE_COMMAND);
    wire selLow  = (capSel == pfpp_pkg::MODE_ADDR_LOW);
    wire selHigh = (capSel == pfpp_pkg::MODE_ADDR_HIGH);
    wire selData = (capSel == pfpp_pkg::MODE_DATA);

    // a new command or a write to another page must flush the buffer first
    wire needCommit = dirty && (selCmd
                    || (selData && is_write_cmd(cmd) && curPage != bufPage));

    wire loadWord = (state == pfpp_pkg::ST_DECODE) && selData && !needCommit
                  && is_write_cmd(cmd) && !secureBit;

    // flash and page buffer ports
    logic [15:0]        flashRdata;
    logic [15:0]        bufRdata;
    wire  [15:0]        lockMask = 16'(lockBits);
    wire  [15:0]        gpMask   = 16'(gpBits);
    wire                commitWe = (state == pfpp_pkg::ST_COMMIT_WR) && !pageLocked
                                 && (loaded[commitIdx] || has_erase(cmd));
    wire                flashWe  = commitWe || (state == pfpp_pkg::ST_ERASE_ALL);
    wire  [ADDR_W-1:0]  flashWaddr = (state == pfpp_pkg::ST_ERASE_ALL) ? eraseIdx
                                   : {bufPage, commitIdx};
    // erase variants write erased words where nothing was loaded
    wire  [15:0]        flashWdata = ((state == pfpp_pkg::ST_COMMIT_WR) && loaded[commitIdx])
                                   ? bufRdata : pfpp_pkg::ERASED_WORD;

    pfpp_mem #(
        .AW (ADDR_W),
        .DW (pfpp_pkg::WORD_W)
    ) flashArray (
        .clk   (clk),
        .we    (flashWe),
        .waddr (flashWaddr),
        .wdata (flashWdata),
        .raddr (wordAddr),
        .rdata (flashRdata)
    );

    pfpp_mem #(
        .AW (PAGE_AW),
        .DW (pfpp_pkg::WORD_W)
    ) pageBuffer (
        .clk   (clk),
        .we    (loadWord),
        .waddr (curIdx),
        .wdata (capWord),
        .raddr (commitIdx),
        .rdata (bufRdata)
    );

    // answer word for read transfers; a secured part hides the array
    wire [15:0] pushData =
        (cmd == pfpp_pkg::CMD_FLASH_READ) ? (secureBit ? 16'h0000 : flashRdata)
      : (cmd == pfpp_pkg::CMD_LOCK_QUERY) ? lockMask
      : (cmd == pfpp_pkg::CMD_GP_BIT_QUERY) ? gpMask
      : {15'h0000, secureBit};

    logic        fifoInReady;
    logic        fifoOutValid;
    logic [15:0] fifoOutData;
    wire         fifoInValid  = (state == pfpp_pkg::ST_FETCH);
    wire         fifoOutReady = (state == pfpp_pkg::ST_WAIT_OE) && !oeN;

    pfpp_fifo2 #(
        .W (pfpp_pkg::WORD_W)
    ) readBuffer (
        .clk      (clk),
        .nrst     (nrst),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (pushData),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    // ready is high only while idle, so a strobe is only taken then
    assign port_ready_out = (state == pfpp_pkg::ST_IDLE);
    assign secure_active  = secureBit;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            selMeta    <= 4'hf;
            selSync    <= 4'hf;
            wordMeta   <= 16'hffff;
            wordSync   <= 16'hffff;
            strobeMeta <= 1'b1;
            strobeN    <= 1'b1;
            oeMeta     <= 1'b1;
            oeN        <= 1'b1;
        end else begin
            selMeta    <= field_select_bus;
            selSync    <= selMeta;
            wordMeta   <= word_bus_in;
            wordSync   <= wordMeta;
            strobeMeta <= command_strobe_n;
            strobeN    <= strobeMeta;
            oeMeta     <= read_drive_enable_n;
            oeN        <= oeMeta;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state               <= pfpp_pkg::ST_IDLE;
            capSel              <= 4'hf;
            capWord             <= 16'h0000;
            cmd                 <= pfpp_pkg::COMMAND_RESET;
            addrLow             <= pfpp_pkg::ADDR_RESET;
            addrHigh            <= pfpp_pkg::ADDR_RESET;
            bufPage             <= '0;
            loaded              <= '0;
            dirty               <= 1'b0;
            commitIdx           <= '0;
            eraseIdx            <= '0;
            lockBits            <= '0;
            gpBits              <= '0;
            secureBit           <= pfpp_pkg::SECURE_RESET;
            word_bus_out        <= 16'h0000;
            word_bus_oe         <= 1'b0;
            read_word_present_n <= 1'b1;
        end else begin
            case (state)
                pfpp_pkg::ST_IDLE: begin
                    if (!strobeN) begin
                        capSel  <= selSync;
                        capWord <= wordSync;
                        state   <= pfpp_pkg::ST_DECODE;
                    end
                end
                pfpp_pkg::ST_DECODE: begin
                    if (needCommit) begin
                        commitIdx <= '0;
                        state     <= pfpp_pkg::ST_COMMIT_RD;
                    end else if (selCmd) begin
                        cmd   <= capWord;
                        state <= pfpp_pkg::ST_WAIT_HIGH;
                    end else if (selLow) begin
                        addrLow <= capWord;
                        state   <= pfpp_pkg::ST_WAIT_HIGH;
                    end else if (selHigh) begin
                        addrHigh <= capWord;
                        state    <= pfpp_pkg::ST_WAIT_HIGH;
                    end else if (selData && is_fetch_cmd(cmd)) begin
                        state <= pfpp_pkg::ST_FETCH;
                    end else if (selData && !secureBit) begin
                        state <= pfpp_pkg::ST_WAIT_HIGH;
                        case (cmd)
                            pfpp_pkg::CMD_PAGE_WRITE, pfpp_pkg::CMD_PAGE_WRITE_LOCK,
                            pfpp_pkg::CMD_ERASE_THEN_WRITE,
                            pfpp_pkg::CMD_ERASE_WRITE_LOCK: begin
                                loaded[curIdx] <= 1'b1;
                                dirty          <= 1'b1;
                                bufPage        <= curPage;
                                addrLow        <= addrNext[15:0];
                                addrHigh       <= addrNext[31:16];
                            end
                            pfpp_pkg::CMD_CHIP_ERASE: begin
                                // any locked region aborts the whole erase
                                if (lockBits == '0) begin
                                    eraseIdx <= '0;
                                    state    <= pfpp_pkg::ST_ERASE_ALL;
                                end
                            end
                            pfpp_pkg::CMD_LOCK_SET: begin
                                lockBits <= lockBits | capWord[LOCK_BITS-1:0];
                            end
                            pfpp_pkg::CMD_LOCK_CLEAR: begin
                                lockBits <= lockBits & ~capWord[LOCK_BITS-1:0];
                            end
                            pfpp_pkg::CMD_GP_BIT_SET: begin
                                gpBits <= gpBits | capWord[GP_BITS-1:0];
                            end
                            pfpp_pkg::CMD_GP_BIT_CLEAR: begin
                                gpBits <= gpBits & ~capWord[GP_BITS-1:0];
                            end
                            pfpp_pkg::CMD_SECURE_BIT_SET: begin
                                secureBit <= 1'b1;
                            end
                            default: begin
                                state <= pfpp_pkg::ST_WAIT_HIGH;
                            end
                        endcase
                    end else begin
                        state <= pfpp_pkg::ST_WAIT_HIGH;
                    end
                end
                pfpp_pkg::ST_COMMIT_RD: begin
                    state <= pfpp_pkg::ST_COMMIT_WR;
                end
                pfpp_pkg::ST_COMMIT_WR: begin
                    if (lastIdx) begin
                        // lock only after the whole page has been written
                        if (has_lock(cmd) && !pageLocked) begin
                            lockBits[bufRegion] <= 1'b1;
                        end
                        loaded    <= '0;
                        dirty     <= 1'b0;
                        commitIdx <= '0;
                        state     <= pfpp_pkg::ST_DECODE;
                    end else begin
                        commitIdx <= commitIdx + PAGE_AW'(1);
                        state     <= pfpp_pkg::ST_COMMIT_RD;
                    end
                end
                pfpp_pkg::ST_ERASE_ALL: begin
                    eraseIdx <= eraseIdx + ADDR_W'(1);
                    if (lastErase) begin
                        lockBits <= '0;
                        gpBits   <= '0;
                        loaded   <= '0;
                        dirty    <= 1'b0;
                        state    <= pfpp_pkg::ST_WAIT_HIGH;
                    end
                end
                pfpp_pkg::ST_FETCH: begin
                    // stall here if the answer buffer is still full
                    if (fifoInReady) begin
                        if (cmd == pfpp_pkg::CMD_FLASH_READ) begin
                            addrLow  <= addrNext[15:0];
                            addrHigh <= addrNext[31:16];
                        end
                        state <= pfpp_pkg::ST_WAIT_OE;
                    end
                end
                pfpp_pkg::ST_WAIT_OE: begin
                    if (fifoOutValid && !oeN) begin
                        word_bus_out        <= fifoOutData;
                        word_bus_oe         <= 1'b1;
                        read_word_present_n <= 1'b0;
                        state               <= pfpp_pkg::ST_DRIVE;
                    end
                end
                pfpp_pkg::ST_DRIVE: begin
                    if (oeN) begin
                        word_bus_oe         <= 1'b0;
                        read_word_present_n <= 1'b1;
                        state               <= pfpp_pkg::ST_WAIT_HIGH;
                    end
                end
                pfpp_pkg::ST_WAIT_HIGH: begin
                    if (strobeN) begin
                        state <= pfpp_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= pfpp_pkg::ST_IDLE;
                end
            endcase
        end
    end
endmodule : pfpp_port
`default_nettype wire

// *** hw/pfpp_pkg.sv ***
// constants shared by the parallel flash program port
package pfpp_pkg;

    // field selector codes
    localparam logic [3:0]  MODE_COMMAND   = 4'h0;
    localparam logic [3:0]  MODE_ADDR_LOW  = 4'h1;
    localparam logic [3:0]  MODE_ADDR_HIGH = 4'h2;
    localparam logic [3:0]  MODE_DATA      = 4'h5;

    // command words
    localparam logic [15:0] CMD_FLASH_READ       = 16'h0011;
    localparam logic [15:0] CMD_PAGE_WRITE       = 16'h0012;
    localparam logic [15:0] CMD_PAGE_WRITE_LOCK  = 16'h0022;
    localparam logic [15:0] CMD_ERASE_THEN_WRITE = 16'h0032;
    localparam logic [15:0] CMD_ERASE_WRITE_LOCK = 16'h0042;
    localparam logic [15:0] CMD_CHIP_ERASE       = 16'h0013;
    localparam logic [15:0] CMD_LOCK_SET         = 16'h0014;
    localparam logic [15:0] CMD_LOCK_CLEAR       = 16'h0024;
    localparam logic [15:0] CMD_LOCK_QUERY       = 16'h0015;
    localparam logic [15:0] CMD_GP_BIT_SET       = 16'h0034;
    localparam logic [15:0] CMD_GP_BIT_CLEAR     = 16'h0044;
    localparam logic [15:0] CMD_GP_BIT_QUERY     = 16'h0025;
    localparam logic [15:0] CMD_SECURE_BIT_SET   = 16'h0054;
    localparam logic [15:0] CMD_SECURE_BIT_QUERY = 16'h0035;

    // values
    localparam logic [15:0] ERASED_WORD   = 16'hffff;
    localparam logic [15:0] COMMAND_RESET = 16'h0000;
    localparam logic [15:0] ADDR_RESET    = 16'h0000;
    localparam logic        SECURE_RESET  = 1'b0;
    localparam int          WORD_W        = 16;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DECODE,
        ST_WAIT_HIGH,
        ST_FETCH,
        ST_WAIT_OE,
        ST_DRIVE,
        ST_COMMIT_RD,
        ST_COMMIT_WR,
        ST_ERASE_ALL
    } pfpp_state_type;

endpackage : pfpp_pkg

// *** hw/pfpp_mem.sv ***
// simple dual-port word memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module pfpp_mem #(
    parameter int AW = 7,
    parameter int DW = 16
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] store [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            store[waddr] <= wdata;
        end
        rdata <= store[raddr];
    end
endmodule : pfpp_mem
`default_nettype wire

// *** hw/pfpp_fifo2.sv ***
// two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module pfpp_fifo2 #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic      [W-1:0] outData
);
    logic [W-1:0] slot [0:1];
    logic         rdPtr;
    logic         wrPtr;
    logic [1:0]   count;
    wire          push = inValid && inReady;
    wire          pop  = outValid && outReady;

    assign inReady  = (count != 2'h2);
    assign outValid = (count != 2'h0);
    assign outData  = slot[rdPtr];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdPtr <= 1'b0;
            wrPtr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wrPtr <= ~wrPtr;
            end
            if (pop) begin
                rdPtr <= ~rdPtr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            slot[wrPtr] <= inData;
        end
    end
endmodule : pfpp_fifo2
`default_nettype wire

// *** hw/pfpp_note_end.sv ***
// intentionally minimal marker file with no module and no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** tb/pfpp_port_props.sv ***
// assertions on the program port handshake
`timescale 1ns/1ps
`default_nettype none
module pfpp_port_props (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [3:0]  field_select_bus,
    input wire logic [15:0] word_bus_in,
    input wire logic [15:0] word_bus_out,
    input wire logic        word_bus_oe,
    input wire logic        command_strobe_n,
    input wire logic        read_drive_enable_n,
    input wire logic        port_ready_out,
    input wire logic        read_word_present_n,
    input wire logic        secure_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_ask;
        $fell(read_drive_enable_n) && !port_ready_out;
    endsequence
    sequence s_show;
        $fell(read_word_present_n);
    endsequence
    a_dir_follows_oe: assert property (word_bus_oe == !read_word_present_n)
        else $error("present flag and drive disagree");
    a_oe_only_busy: assert property (word_bus_oe |-> !port_ready_out)
        else $error("bus driven while ready");
    a_ack_after_strobe: assert property ($fell(port_ready_out) |-> !$past(command_strobe_n, 2))
        else $error("ready fell without strobe");
    a_ready_after_high: assert property ($rose(port_ready_out) |-> $past(command_strobe_n, 2))
        else $error("ready rose under low strobe");
    a_busy_holds_low: assert property (!port_ready_out && !command_strobe_n |=> !port_ready_out)
        else $error("ready rose too early");
    a_drive_on_enable: assert property ($fell(read_word_present_n) |-> !$past(read_drive_enable_n, 2))
        else $error("word driven without enable");
    a_release_on_high: assert property ($rose(read_word_present_n) |-> $past(read_drive_enable_n, 2))
        else $error("bus released under low enable");
    a_read_answered: assert property (s_ask |-> ##[2:40] s_show)
        else $error("read word never shown");
endmodule : pfpp_port_props
bind pfpp_port pfpp_port_props u_props (.clk(clk), .nrst(nrst),
    .field_select_bus(field_select_bus), .word_bus_in(word_bus_in),
    .word_bus_out(word_bus_out), .word_bus_oe(word_bus_oe),
    .command_strobe_n(command_strobe_n), .read_drive_enable_n(read_drive_enable_n),
    .port_ready_out(port_ready_out), .read_word_present_n(read_word_present_n),
    .secure_active(secure_active));
`default_nettype wire

// *** tb/pfpp_prog.sv ***
// behavioural gang programmer driving the parallel handshake
`timescale 1ns/1ps
`default_nettype none
module pfpp_prog (
    input  wire logic        clk,
    input  wire logic        rdy,
    input  wire logic        presentN,
    input  wire logic        oe,
    input  wire logic [15:0] devWord,
    output logic             strobeN,
    output logic             enableN,
    output logic [3:0]       sel,
    output logic [15:0]      pins
);
    logic [15:0] hostWord;
    logic        hostDrive;
    // released pins float up to the pull-up level, never to the last value
    assign pins = oe ? devWord : (hostDrive ? hostWord : 16'hffff);
    initial begin
        strobeN = 1'b1;
        enableN = 1'b1;
        sel = 4'hf;
        hostDrive = 1'b0;
        hostWord = 16'h0000;
    end
    task automatic xfer(input logic [3:0] s, input logic [15:0] d, input bit rd,
                        output logic [15:0] q);
        int n;
        q = 16'h0000;
        for (n = 0; n < 4000 && !rdy; n++) @(negedge clk);
        sel = s;
        hostWord = d;
        hostDrive = 1'b1;
        // synchronisers need the word settled before the strobe
        repeat (3) @(negedge clk);
        strobeN = 1'b0;
        for (n = 0; n < 4000 && rdy; n++) @(negedge clk);
        sel = 4'hf;
        hostDrive = 1'b0;
        if (rd) begin
            enableN = 1'b0;
            for (n = 0; n < 4000 && presentN; n++) @(negedge clk);
            q = devWord;
            enableN = 1'b1;
            for (n = 0; n < 4000 && !presentN; n++) @(negedge clk);
        end
        strobeN = 1'b1;
        for (n = 0; n < 4000 && !rdy; n++) @(negedge clk);
    endtask : xfer
endmodule : pfpp_prog
`default_nettype wire

// *** tb/pfpp_port_tb.sv ***
// self-checking bench for the parallel flash program port
`timescale 1ns/1ps
`default_nettype none
module pfpp_port_tb;
    logic        clk, nrst, strobeN, enableN, ready, presentN, oe, secure;
    logic [3:0]  sel;
    logic [15:0] pins, devWord, q;
    logic [15:0] w0[4], w1[4];
    logic [15:0] cmds[4] = '{16'h0012, 16'h0022, 16'h0032, 16'h0042};
    int          bad_count, check_count, lockMask, i;
    pfpp_port #(.PAGE_AW(3), .PAGES_AW(4), .REGION_AW(2), .GP_BITS(3)) dut (
        .clk(clk), .nrst(nrst), .field_select_bus(sel), .word_bus_in(pins),
        .word_bus_out(devWord), .word_bus_oe(oe), .command_strobe_n(strobeN),
        .read_drive_enable_n(enableN), .port_ready_out(ready),
        .read_word_present_n(presentN), .secure_active(secure));
    pfpp_prog prog (.clk(clk), .rdy(ready), .presentN(presentN), .oe(oe),
        .devWord(devWord), .strobeN(strobeN), .enableN(enableN), .sel(sel), .pins(pins));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic op(input logic [3:0] s, input logic [15:0] d);
        prog.xfer(s, d, 1'b0, q);
    endtask : op
    task automatic rdc(input logic [15:0] e);
        prog.xfer(4'h5, 16'h0000, 1'b1, q);
        chk(q, e);
    endtask : rdc
    task automatic setA(input logic [15:0] a);
        op(4'h1, a);
        op(4'h2, 16'h0000);
    endtask : setA
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // about 1500 cycles expected; this allows about ten times that
    initial begin
        #400000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        nrst = 1'b0;
        bad_count = 0;
        check_count = 0;
        lockMask = 0;
        void'($urandom(15825));
        repeat (3) @(negedge clk);
        chk({12'h000, ready, presentN, oe, secure}, 16'h000c);
        nrst = 1'b1;
        // entry wait cut to a few cycles; the port keeps no timer of its own
        repeat (4) @(negedge clk);
        op(4'h0, 16'h0013);
        op(4'h5, 16'h0000);
        for (i = 0; i < 4; i++) begin
            w0[i] = 16'($urandom);
            w1[i] = 16'($urandom);
            op(4'h0, 16'h0012);
            setA(16'(i * 32));
            op(4'h5, w0[i]);
            op(4'h0, cmds[i]);
            setA(16'(i * 32 + 1));
            op(4'h5, w1[i]);
            op(4'h0, 16'h0011);
            setA(16'(i * 32));
            rdc(i >= 2 ? 16'hffff : w0[i]);
            rdc(w1[i]);
            lockMask |= (i & 1) << i;
        end
        op(4'h0, 16'h0015);
        rdc(16'(lockMask));
        // region 0: plain writes on leading pages, lock variant on its last page
        op(4'h0, 16'h0012);
        setA(16'h0002);
        op(4'h5, w0[1]);
        setA(16'h0010);
        op(4'h5, w0[2]);
        op(4'h0, 16'h0022);
        setA(16'h0018);
        op(4'h5, w1[1]);
        op(4'h0, 16'h0011);
        setA(16'h0002);
        rdc(w0[1]);
        op(4'h0, 16'h0015);
        rdc(16'(lockMask | 1));
        op(4'h0, 16'h0013);
        op(4'h5, 16'h0000);
        op(4'h0, 16'h0011);
        setA(16'h0001);
        rdc(w1[0]);
        op(4'h0, 16'h0024);
        op(4'h5, 16'hffff);
        op(4'h0, 16'h0014);
        op(4'h5, 16'h0004);
        op(4'h0, 16'h0015);
        rdc(16'h0004);
        op(4'h0, 16'h0024);
        op(4'h5, 16'h0004);
        op(4'h0, 16'h0013);
        op(4'h5, 16'h0000);
        op(4'h0, 16'h0011);
        setA(16'h0001);
        rdc(16'hffff);
        op(4'h0, 16'h0034);
        op(4'h5, 16'h0005);
        op(4'h0, 16'h0044);
        op(4'h5, 16'h0001);
        op(4'h3, 16'h0034);
        op(4'h0, 16'h0077);
        op(4'h5, 16'h0007);
        op(4'h0, 16'h0025);
        rdc(16'h0004);
        op(4'h0, 16'h0054);
        op(4'h5, 16'h0000);
        chk({15'h0000, secure}, 16'h0001);
        op(4'h0, 16'h0035);
        rdc(16'h0001);
        // a secured part hides the array behind zero words
        op(4'h0, 16'h0011);
        setA(16'h0001);
        rdc(16'h0000);
        tally_and_finish();
    end
endmodule : pfpp_port_tb
`default_nettype wire
